// *** fpfd_defs.vh ***
// Constants for the floating-point instruction format decoder
// ==========================================================
// Behaviour
// - Five-bit format 16 single, 17 double, 20 word, 21 long, 22 paired, rest reserved.
// - Short format 0 single, 1 double, 4 word, 5 long, 6 paired; 2, 3, 7 reserved.
// - Operands are 32 bits for single and word, 64 for double and long, 2x32 for paired.
// - Conversions take result format from function field, others keep source format.
// - Unsupported operation-format pairs do not execute and raise reserved-instruction.
// - Function 5 magnitude, 0 add, 48-63 compare: legal for float formats, not integers.
// - Each instruction is one 32-bit word from a word-aligned address.
// - Only opcode, format and function select the operation.
// - The destination may come from any of the three register specifier fields.
// - Loads and stores use opcode 31:26, base 25:21, float register 20:16, offset 15:0.
// - Arithmetic uses op 31:26, fmt 25:21, second 20:16, first 15:11, result 10:6, fn 5:0.
// - A set nullify bit makes a branch likely; its slot is suppressed when not taken.
// - Branches and moves act when the selected condition bit equals the true/false bit.
`ifndef FPFD_DEFS_VH
`define FPFD_DEFS_VH

// ==========================================================
// Field positions
`define FPFD_OP_HI 31
`define FPFD_OP_LO 26
`define FPFD_FMT_HI 25
`define FPFD_FMT_LO 21
`define FPFD_FT_HI 20
`define FPFD_FT_LO 16
`define FPFD_FS_HI 15
`define FPFD_FS_LO 11
`define FPFD_FD_HI 10
`define FPFD_FD_LO 6
`define FPFD_FN_HI 5
`define FPFD_FN_LO 0
`define FPFD_OFS_HI 15
`define FPFD_OFS_LO 0
`define FPFD_SFMT_HI 2
`define FPFD_SFMT_LO 0
`define FPFD_ND_BIT 17
`define FPFD_TF_BIT 16
`define FPFD_CC_HI 20
`define FPFD_CC_LO 18
`define FPFD_ALIGN_HI 1
`define FPFD_ALIGN_LO 0

// ==========================================================
// Five-bit format codes
`define FPFD_FMT_S 5'h10
`define FPFD_FMT_D 5'h11
`define FPFD_FMT_W 5'h14
`define FPFD_FMT_L 5'h15
`define FPFD_FMT_PS 5'h16

// Three-bit format codes
`define FPFD_SF_S 3'h0
`define FPFD_SF_D 3'h1
`define FPFD_SF_W 3'h4
`define FPFD_SF_L 3'h5
`define FPFD_SF_PS 3'h6

// Internal one-hot format class: {long, word, paired, double, single}
`define FPFD_CL_NONE 5'h00
`define FPFD_CL_S 5'h01
`define FPFD_CL_D 5'h02
`define FPFD_CL_PS 5'h04
`define FPFD_CL_W 5'h08
`define FPFD_CL_L 5'h10
`define FPFD_CL_FLOAT 5'h07

// Operand width codes
`define FPFD_WID_NONE 2'h0
`define FPFD_WID_32 2'h1
`define FPFD_WID_64 2'h2
`define FPFD_WID_2X32 2'h3

// ==========================================================
// Function codes
`define FPFD_FN_ADD 6'h00
`define FPFD_FN_MAG 6'h05
`define FPFD_FN_CMP_MASK 6'h30
`define FPFD_FN_CVT_MASK 6'h38
`define FPFD_FN_CVT_BASE 6'h20
`define FPFD_FN_CVT_S 6'h20
`define FPFD_FN_CVT_D 6'h21
`define FPFD_FN_CVT_W 6'h24
`define FPFD_FN_CVT_L 6'h25
`define FPFD_FN_CVT_PS 6'h26

// Primary opcode defaults
`define FPFD_OPC_FPU 6'h11
`define FPFD_OPC_FPUX 6'h13

// Destination source select
`define FPFD_DSEL_FD 2'h0
`define FPFD_DSEL_FS 2'h1
`define FPFD_DSEL_FT 2'h2

// Reset values of the registered fields
`define FPFD_RST_OPC 6'h00
`define FPFD_RST_FN 6'h00
`define FPFD_RST_REG 5'h00
`define FPFD_RST_OFS 16'h0000

`endif

// *** fpfd_format_map.v ***
// Format field to format class and operand width mapper
`timescale 1ns/1ps
`include "fpfd_defs.vh"

module fpfd_format_map (
    // Field in
    input wire [4:0] fmtField,
    input wire shortForm,
    // Class out
    output reg [4:0] fmtClass,
    output reg [1:0] opWidth
);

    always @* begin
        fmtClass = `FPFD_CL_NONE;
        if (shortForm) begin
            case (fmtField[`FPFD_SFMT_HI:`FPFD_SFMT_LO])
                `FPFD_SF_S: fmtClass = `FPFD_CL_S;
                `FPFD_SF_D: fmtClass = `FPFD_CL_D;
                `FPFD_SF_W: fmtClass = `FPFD_CL_W;
                `FPFD_SF_L: fmtClass = `FPFD_CL_L;
                `FPFD_SF_PS: fmtClass = `FPFD_CL_PS;
                default: fmtClass = `FPFD_CL_NONE;
            endcase
        end else begin
            case (fmtField)
                `FPFD_FMT_S: fmtClass = `FPFD_CL_S;
                `FPFD_FMT_D: fmtClass = `FPFD_CL_D;
                `FPFD_FMT_W: fmtClass = `FPFD_CL_W;
                `FPFD_FMT_L: fmtClass = `FPFD_CL_L;
                `FPFD_FMT_PS: fmtClass = `FPFD_CL_PS;
                default: fmtClass = `FPFD_CL_NONE;
            endcase
        end
        case (fmtClass)
            `FPFD_CL_S, `FPFD_CL_W: opWidth = `FPFD_WID_32;
            `FPFD_CL_D, `FPFD_CL_L: opWidth = `FPFD_WID_64;
            `FPFD_CL_PS: opWidth = `FPFD_WID_2X32;
            default: opWidth = `FPFD_WID_NONE;
        endcase
    end

endmodule

// *** fpfd_format_decoder.v ***
// Floating-point instruction format decoder, one registered stage
`timescale 1ns/1ps
`include "fpfd_defs.vh"

module fpfd_format_decoder #(
    parameter [5:0] FPU_PRIMARY_OPCODE = `FPFD_OPC_FPU,
    parameter [5:0] FPU_EXTENDED_OPCODE = `FPFD_OPC_FPUX
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Instruction in
    input wire instrValid,
    input wire [31:0] instrWord,
    input wire [31:0] instrAddr,
    input wire [1:0] destSelect,
    input wire shortFormat,
    input wire [7:0] condCodes,
    input wire branchTaken,
    // Decode out
    output reg decodeValid,
    output reg reservedInstr,
    output reg misalignedFetch,
    output reg [5:0] primaryOpcode,
    output reg [4:0] fmtClass,
    output reg [1:0] opWidth,
    output reg [4:0] resultClass,
    output reg [1:0] resultWidth,
    output reg isConvert,
    output reg isMagnitude,
    output reg isAdd,
    output reg isCompare,
    output reg [5:0] functionCode,
    output reg [4:0] firstSourceReg,
    output reg [4:0] secondOperandReg,
    output reg [4:0] resultReg,
    output reg [4:0] destReg,
    output reg [4:0] baseReg,
    output reg [15:0] offsetField,
    output reg nullifyDelayBit,
    output reg trueFalseSelect,
    output reg condActionTaken,
    output reg suppressDelaySlot
);

    // ==========================================================
    // Field extraction
    wire [5:0] opField = instrWord[`FPFD_OP_HI:`FPFD_OP_LO];
    wire [4:0] fmtField = instrWord[`FPFD_FMT_HI:`FPFD_FMT_LO];
    wire [4:0] ftField = instrWord[`FPFD_FT_HI:`FPFD_FT_LO];
    wire [4:0] fsField = instrWord[`FPFD_FS_HI:`FPFD_FS_LO];
    wire [4:0] fdField = instrWord[`FPFD_FD_HI:`FPFD_FD_LO];
    wire [5:0] fnField = instrWord[`FPFD_FN_HI:`FPFD_FN_LO];
    wire [15:0] ofsField = instrWord[`FPFD_OFS_HI:`FPFD_OFS_LO];
    // Branch and move layout puts nullify, true/false and condition index here
    wire ndField = instrWord[`FPFD_ND_BIT];
    wire tfField = instrWord[`FPFD_TF_BIT];
    wire [2:0] ccIndex = instrWord[`FPFD_CC_HI:`FPFD_CC_LO];

    // ==========================================================
    // Source format
    // Short-form format sits in the low bits of the function field
    wire useShort = shortFormat && (opField == FPU_EXTENDED_OPCODE);
    wire [4:0] mapField = useShort ? {2'h0, fnField[`FPFD_SFMT_HI:`FPFD_SFMT_LO]} : fmtField;

    wire [4:0] srcClass;
    wire [1:0] srcWidth;

    // One mapper serves both field forms; the short form is zero-extended
    fpfd_format_map srcMap (
        .fmtField(mapField),
        .shortForm(useShort),
        .fmtClass(srcClass),
        .opWidth(srcWidth)
    );

    // ==========================================================
    // Operation classification, opcode/format/function only
    // Magnitude, add and compare decode only under the primary opcode
    wire isFpuOp = (opField == FPU_PRIMARY_OPCODE);
    wire magOp = isFpuOp && (fnField == `FPFD_FN_MAG);
    wire addOp = isFpuOp && (fnField == `FPFD_FN_ADD);
    wire cmpOp = isFpuOp && ((fnField & `FPFD_FN_CMP_MASK) == `FPFD_FN_CMP_MASK);
    wire cvtOp = isFpuOp && ((fnField & `FPFD_FN_CVT_MASK) == `FPFD_FN_CVT_BASE);
    // These three exist only for the float group of formats
    wire floatOnly = magOp || addOp || cmpOp;
    // Single, double and paired form the float group
    wire srcIsFloat = |(srcClass & `FPFD_CL_FLOAT);
    // The short form is checked as well, as its format rides in the function bits
    wire fmtReserved = (isFpuOp || useShort) && (srcClass == `FPFD_CL_NONE);
    wire fmtIllegal = floatOnly && !srcIsFloat;

    // ==========================================================
    // Result format
    // Conversion target comes from the function field
    reg [4:0] cvtClass;
    always @* begin
        case (fnField)
            `FPFD_FN_CVT_S: cvtClass = `FPFD_CL_S;
            `FPFD_FN_CVT_D: cvtClass = `FPFD_CL_D;
            `FPFD_FN_CVT_W: cvtClass = `FPFD_CL_W;
            `FPFD_FN_CVT_L: cvtClass = `FPFD_CL_L;
            `FPFD_FN_CVT_PS: cvtClass = `FPFD_CL_PS;
            default: cvtClass = `FPFD_CL_NONE;
        endcase
    end
    // A conversion code with no defined target is refused like a bad format
    wire cvtBad = cvtOp && (cvtClass == `FPFD_CL_NONE);
    wire [4:0] resClassNext = cvtOp ? cvtClass : srcClass;

    // Width follows the result class, so a conversion may change it
    reg [1:0] resWidthNext;
    always @* begin
        case (resClassNext)
            `FPFD_CL_S, `FPFD_CL_W: resWidthNext = `FPFD_WID_32;
            `FPFD_CL_D, `FPFD_CL_L: resWidthNext = `FPFD_WID_64;
            `FPFD_CL_PS: resWidthNext = `FPFD_WID_2X32;
            default: resWidthNext = `FPFD_WID_NONE;
        endcase
    end

    // ==========================================================
    // Exception
    // Fetch must be one word at a word-aligned address
    wire misalignNext = |instrAddr[`FPFD_ALIGN_HI:`FPFD_ALIGN_LO];
    // Reserved format, unsupported combination or bad fetch blocks execution
    wire reservedNext = fmtReserved || fmtIllegal || cvtBad || misalignNext;

    // ==========================================================
    // Destination and conditions
    // Destination may live in any of the three specifier fields
    // Select code 3 is unused and falls back to the result field
    reg [4:0] destNext;
    always @* begin
        case (destSelect)
            `FPFD_DSEL_FS: destNext = fsField;
            `FPFD_DSEL_FT: destNext = ftField;
            default: destNext = fdField;
        endcase
    end

    // Condition codes come from the same clock, so no synchroniser is needed
    wire condNext = (condCodes[ccIndex] == tfField);
    // Only a likely branch that falls through kills its slot
    wire suppressNext = ndField && !branchTaken;

    // ==========================================================
    // Output stage: event flags
    // Flags are qualified so a bubble never raises an exception
    // Misalignment also stands alone so fetch can tell it from a bad format
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            decodeValid <= 1'b0;
            reservedInstr <= 1'b0;
            misalignedFetch <= 1'b0;
            condActionTaken <= 1'b0;
            suppressDelaySlot <= 1'b0;
        end else begin
            decodeValid <= instrValid;
            reservedInstr <= instrValid && reservedNext;
            misalignedFetch <= instrValid && misalignNext;
            suppressDelaySlot <= instrValid && suppressNext;
            condActionTaken <= instrValid && condNext;
        end
    end

    // ==========================================================
    // Output stage: format and operation class
    // Held across bubbles so the datapath can keep reading the last word
    // Class outputs only carry meaning while the opcode matched
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            primaryOpcode <= `FPFD_RST_OPC;
            fmtClass <= `FPFD_CL_NONE;
            opWidth <= `FPFD_WID_NONE;
            resultClass <= `FPFD_CL_NONE;
            resultWidth <= `FPFD_WID_NONE;
            isConvert <= 1'b0;
            isMagnitude <= 1'b0;
            isAdd <= 1'b0;
            isCompare <= 1'b0;
            functionCode <= `FPFD_RST_FN;
        end else if (instrValid) begin
            primaryOpcode <= opField;
            fmtClass <= srcClass;
            opWidth <= srcWidth;
            resultClass <= resClassNext;
            resultWidth <= resWidthNext;
            isConvert <= cvtOp;
            isMagnitude <= magOp;
            isAdd <= addOp;
            isCompare <= cmpOp;
            functionCode <= fnField;
        end
    end

    // ==========================================================
    // Output stage: operand specifiers
    // Specifiers are copied whole; decode never looks at them
    // The pipeline picks the destination slot since it knows the full opcode
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            firstSourceReg <= `FPFD_RST_REG;
            secondOperandReg <= `FPFD_RST_REG;
            resultReg <= `FPFD_RST_REG;
            destReg <= `FPFD_RST_REG;
            baseReg <= `FPFD_RST_REG;
            offsetField <= `FPFD_RST_OFS;
            nullifyDelayBit <= 1'b0;
            trueFalseSelect <= 1'b0;
        end else if (instrValid) begin
            firstSourceReg <= fsField;
            secondOperandReg <= ftField;
            resultReg <= fdField;
            destReg <= destNext;
            baseReg <= fmtField;
            offsetField <= ofsField;
            nullifyDelayBit <= ndField;
            trueFalseSelect <= tfField;
        end
    end

endmodule

// *** fpfd_issuer.sv ***
// Pipeline issue model that feeds instruction words to the decoder
`timescale 1ns/1ps
module fpfd_issuer (
    // Clock
    input wire logic clk,
    // Issue side
    output logic instrValid,
    output logic [31:0] instrWord,
    output logic [31:0] instrAddr,
    output logic [1:0] destSelect,
    output logic shortFormat,
    output logic [7:0] condCodes,
    output logic branchTaken
);
    initial begin
        {instrValid, instrWord, instrAddr, destSelect, shortFormat, condCodes, branchTaken} = '0;
    end
    // One whole word per edge, back to back allowed
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [1:0] ds,
                         input logic sf, input logic [7:0] cc, input logic bt);
        @(posedge clk);
        #1;
        instrValid = 1'b1;
        instrWord = w;
        instrAddr = a;
        {destSelect, shortFormat, condCodes, branchTaken} = {ds, sf, cc, bt};
    endtask
    // A released word bus must not keep showing the last word
    task automatic idle;
        @(posedge clk);
        #1;
        instrValid = 1'b0;
        instrWord = ~instrWord;
    endtask
endmodule

// *** fpfd_checker.sv ***
// Assertion checker for the floating-point format decoder
`timescale 1ns/1ps
`include "fpfd_defs.vh"
module fpfd_checker (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Inputs watched
    input wire instrValid,
    input wire [31:0] instrWord,
    input wire [31:0] instrAddr,
    input wire [7:0] condCodes,
    input wire branchTaken,
    // Outputs watched
    input wire decodeValid,
    input wire reservedInstr,
    input wire misalignedFetch,
    input wire [4:0] fmtClass,
    input wire [1:0] opWidth,
    input wire [4:0] firstSourceReg,
    input wire [4:0] secondOperandReg,
    input wire [4:0] resultReg,
    input wire [5:0] functionCode,
    input wire condActionTaken,
    input wire suppressDelaySlot
);
    // ==========================================================
    // Expectations captured with each word
    logic [31:0] w;
    logic condOk;
    logic slotOk;
    wire fpu = instrValid && instrWord[31:26] == `FPFD_OPC_FPU;
    wire [4:0] f = instrWord[25:21];
    wire [5:0] fn = instrWord[5:0];
    always @(posedge clk) begin
        w <= instrWord;
        condOk <= condCodes[instrWord[20:18]] == instrWord[16];
        slotOk <= instrWord[17] && !branchTaken;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Properties
    property p_valid; 1'b1 |=> decodeValid == $past(instrValid); endproperty
    a_valid: assert property (p_valid) else $error("decode valid wrong");
    property p_single; fpu && f == 5'h10 |=> fmtClass == 5'h01 && opWidth == 2'h1; endproperty
    a_single: assert property (p_single) else $error("single format wrong");
    property p_resv; fpu && !(f inside {5'h10, 5'h11, 5'h14, 5'h15, 5'h16}) |=> reservedInstr;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved format accepted");
    property p_intop;
        fpu && f[4:1] == 4'ha && (fn == 6'h00 || fn == 6'h05 || fn[5:4] == 2'h3) |=> reservedInstr;
    endproperty
    a_intop: assert property (p_intop) else $error("integer format accepted");
    property p_align; instrValid && instrAddr[1:0] != 2'h0 |=> misalignedFetch && reservedInstr;
    endproperty
    a_align: assert property (p_align) else $error("misaligned word accepted");
    property p_fields; instrValid |=> {firstSourceReg, secondOperandReg, resultReg, functionCode}
        == {w[15:11], w[20:16], w[10:6], w[5:0]}; endproperty
    a_fields: assert property (p_fields) else $error("register fields wrong");
    property p_cond; instrValid |=> condActionTaken == condOk; endproperty
    a_cond: assert property (p_cond) else $error("condition test wrong");
    property p_slot; instrValid |=> suppressDelaySlot == slotOk; endproperty
    a_slot: assert property (p_slot) else $error("delay slot wrong");
endmodule
bind fpfd_format_decoder fpfd_checker chk (.clk, .nrst, .instrValid, .instrWord, .instrAddr,
    .condCodes, .branchTaken, .decodeValid, .reservedInstr, .misalignedFetch, .fmtClass,
    .opWidth, .firstSourceReg, .secondOperandReg, .resultReg, .functionCode, .condActionTaken,
    .suppressDelaySlot);

// *** tb.sv ***
// Self-checking testbench for the floating-point format decoder
`timescale 1ns/1ps
module tb;
    logic clk, nrst, instrValid, shortFormat, branchTaken;
    logic [31:0] instrWord, instrAddr;
    logic [1:0] destSelect, opWidth, resultWidth;
    logic [7:0] condCodes;
    logic decodeValid, reservedInstr, misalignedFetch, isConvert, isMagnitude, isAdd, isCompare;
    logic nullifyDelayBit, trueFalseSelect, condActionTaken, suppressDelaySlot;
    logic [5:0] primaryOpcode, functionCode;
    logic [4:0] fmtClass, resultClass, firstSourceReg, secondOperandReg, resultReg;
    logic [4:0] destReg, baseReg;
    logic [15:0] offsetField;
    int num_errors = 0;
    int tests_run = 0;
    fpfd_issuer pipe (.clk, .instrValid, .instrWord, .instrAddr, .destSelect, .shortFormat,
        .condCodes, .branchTaken);
    fpfd_format_decoder uut (.clk, .nrst, .instrValid, .instrWord, .instrAddr, .destSelect,
        .shortFormat, .condCodes, .branchTaken, .decodeValid, .reservedInstr, .misalignedFetch,
        .primaryOpcode, .fmtClass, .opWidth, .resultClass, .resultWidth, .isConvert, .isMagnitude,
        .isAdd, .isCompare, .functionCode, .firstSourceReg, .secondOperandReg, .resultReg,
        .destReg, .baseReg, .offsetField, .nullifyDelayBit, .trueFalseSelect, .condActionTaken,
        .suppressDelaySlot);
    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One word, then an idle edge so its decode is settled on return
    task automatic run(input logic [31:0] w, input logic [31:0] a = 0, input logic [1:0] ds = 0,
                       input logic sf = 0);
        pipe.issue(w, a, ds, sf, 8'h00, 1'b0);
        pipe.idle();
    endtask
    task automatic results;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_formats;
        logic [6:0] e;
        logic r;
        for (int f = 0; f < 32; f++) begin
            case (f)
                16: e = {5'h01, 2'h1};
                17: e = {5'h02, 2'h2};
                20: e = {5'h08, 2'h1};
                21: e = {5'h10, 2'h2};
                22: e = {5'h04, 2'h3};
                default: e = 7'h00;
            endcase
            run({6'h11, f[4:0], 15'h0000, 6'h05});
            chk("fmtClass", 32'(fmtClass), 32'(e[6:2]));
            chk("opWidth", 32'(opWidth), 32'(e[1:0]));
            chk("magnitude", 32'(isMagnitude), 32'h1);
            r = e[6:2] == 5'h00 || e[6:5] != 2'h0;
            chk("reserved", 32'(reservedInstr), 32'(r));
        end
    endtask
    task automatic t_short;
        logic [4:0] sc [8] = '{5'h01, 5'h02, 5'h00, 5'h00, 5'h08, 5'h10, 5'h04, 5'h00};
        logic [4:0] e;
        for (int s = 0; s < 8; s++) begin
            e = sc[s];
            run({6'h13, 20'h00000, 3'h0, s[2:0]}, 32'h0, 2'h0, 1'b1);
            chk("shortClass", 32'(fmtClass), 32'(e));
            chk("shortReserved", 32'(reservedInstr), 32'(e == 5'h00));
        end
    endtask
    task automatic t_ops;
        logic [5:0] fns [4] = '{6'h00, 6'h05, 6'h30, 6'h3f};
        foreach (fns[i]) begin
            run({6'h11, 5'h10, 15'h0000, fns[i]});
            chk("legal", 32'(reservedInstr), 32'h0);
            chk("isAdd", 32'(isAdd), 32'(i == 0));
            chk("isCompare", 32'(isCompare), 32'(i > 1));
            run({6'h11, 5'h15, 15'h0000, fns[i]});
            chk("illegal", 32'(reservedInstr), 32'h1);
        end
    endtask
    task automatic t_convert;
        run({6'h11, 5'h10, 15'h0000, 6'h21});
        chk("cvt", 32'({isConvert, resultClass, resultWidth}), 32'h8a);
        run({6'h11, 5'h16, 15'h0000, 6'h00});
        chk("same", 32'({resultClass, resultWidth}), 32'({5'h04, 2'h3}));
    endtask
    task automatic t_fields;
        logic [4:0] d [4] = '{5'h1e, 5'h15, 5'h0a, 5'h1e};
        for (int i = 0; i < 4; i++) begin
            run({6'h11, 5'h11, 5'h0a, 5'h15, 5'h1e, 6'h00}, 32'h0, i[1:0]);
            chk("destReg", 32'(destReg), 32'(d[i]));
        end
        chk("regs", 32'({firstSourceReg, secondOperandReg, resultReg}), 32'h555e);
        chk("loadStore", 32'({baseReg, offsetField}), 32'h11af80);
        chk("opcode", 32'(primaryOpcode), 32'h11);
        chk("fieldsIgnored", 32'(reservedInstr), 32'h0);
    endtask
    task automatic t_branch;
        pipe.issue({6'h11, 5'h08, 3'h5, 2'h3, 16'h0000}, 32'h0, 2'h0, 1'b0, 8'h20, 1'b0);
        pipe.issue({6'h11, 5'h08, 3'h5, 2'h3, 16'h0000}, 32'h4, 2'h0, 1'b0, 8'hdf, 1'b1);
        chk("ndTf", 32'({nullifyDelayBit, trueFalseSelect}), 32'h3);
        chk("condTrue", 32'({condActionTaken, suppressDelaySlot}), 32'h3);
        pipe.idle();
        chk("condFalse", 32'({condActionTaken, suppressDelaySlot}), 32'h0);
        pipe.idle();
        chk("flagsDrop", 32'({decodeValid, condActionTaken}), 32'h0);
    endtask
    task automatic t_align;
        run({6'h11, 5'h10, 15'h0000, 6'h00}, 32'h0102);
        chk("misaligned", 32'({misalignedFetch, reservedInstr}), 32'h3);
        run({6'h11, 5'h10, 15'h0000, 6'h00}, 32'h0104);
        chk("aligned", 32'({misalignedFetch, reservedInstr}), 32'h0);
    endtask
    // ==========================================================
    // Clock, reset and sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_formats();
        t_short();
        t_ops();
        t_convert();
        t_fields();
        t_branch();
        t_align();
        results();
    end
endmodule
